/* quad_hdlc_consts.vh */
// constants for the quad hdlc host port and mode selection
// assumes an internal 8-bit register address space and a 10 mhz core clock
`ifndef QUAD_HDLC_CONSTS_VH
`define QUAD_HDLC_CONSTS_VH

`define CONN_SINGLE_SLOT 2'h0
`define CONN_QUAD_STROBE 2'h1
`define CONN_SINGLE_IOM 2'h2
`define CONN_QUAD_SLOT 2'h3

`define COLL_UNCOND 2'h0
`define COLL_SLAVE 2'h1
`define COLL_MULTI 2'h2

`define ADDR_CCR 8'h40
`define CH_AREA_BIT 7
`define CH_SEL_HI 5
`define CH_SEL_LO 4
`define CH_REG_MODE 4'h0
`define CH_REG_SLOT 4'h1
`define CH_REG_STATUS 4'h2

`define MODE_SLOT_W_LO 0
`define MODE_COLL_LO 2
`define CCR_CONN_LO 0
`define CCR_RESET 8'h00
`define MODE_RESET 8'h00
`define SLOT_RESET 8'h00

`define IOM_SLOT_W 2'h0
`define IOM_SLOT_CH0 8'h0c
`define IOM_SLOT_CH1 8'h1c
`define IOM_SLOT_CH2 8'h2c
`define IOM_SLOT_CH3 8'h3c

`define XFORM_NONE 2'h0
`define XFORM_EVEN 2'h1
`define XFORM_ODD 2'h2

`endif

/* host_bus_decoder.v */
// strobe and address front end of the host port
// assumes all bus pins are already synchronous to clk_i
`timescale 1ns/1ps
module host_bus_decoder (
    input wire clk_i,
    input wire resetn_i,
    input wire soft_reset_i,
    input wire cs_n_i,
    input wire wr_n_or_dir_i,
    input wire rd_n_or_bus_strobe_i,
    input wire ale_i,
    input wire [7:0] shared_bus_i,
    input wire [6:0] reg_sel_i,
    output wire mux_mode_o,
    output wire dir_style_o,
    output wire [7:0] addr_o,
    output wire [7:0] wdata_o,
    output wire wr_pulse_o,
    output wire rd_active_o
);
    reg ale_prev_q;
    reg mux_seen_q;
    reg [7:0] addr_latch_q;
    reg [7:0] wdata_q;
    reg wr_act_q;
    wire wr_act;
    wire rd_act;
    wire dir_style;

    // a moving latch enable means muxed; a static high means direction style
    assign dir_style = ~mux_seen_q & ale_i;
    assign wr_act = ~cs_n_i & (dir_style ? (~rd_n_or_bus_strobe_i & ~wr_n_or_dir_i)
                                         : ~wr_n_or_dir_i);
    assign rd_act = ~cs_n_i & (dir_style ? (~rd_n_or_bus_strobe_i & wr_n_or_dir_i)
                                         : ~rd_n_or_bus_strobe_i);

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ale_prev_q <= 1'b0;
            mux_seen_q <= 1'b0;
            addr_latch_q <= 8'h00;
            wdata_q <= 8'h00;
            wr_act_q <= 1'b0;
        end else if (soft_reset_i) begin
            ale_prev_q <= 1'b0;
            mux_seen_q <= 1'b0;
            addr_latch_q <= 8'h00;
            wdata_q <= 8'h00;
            wr_act_q <= 1'b0;
        end else begin
            ale_prev_q <= ale_i;
            if (ale_prev_q && !ale_i) begin
                mux_seen_q <= 1'b1;
            end
            // latch follows the bus only while enable is high, then holds
            if (ale_i) begin
                addr_latch_q <= shared_bus_i;
            end
            if (wr_act) begin
                wdata_q <= shared_bus_i;
            end
            wr_act_q <= wr_act;
        end
    end

    // write commits at the end of the strobe, with data seen while it was low
    assign wr_pulse_o = wr_act_q & ~wr_act;
    // direction style holds latch enable high, so only a muxed address phase blocks reads
    assign rd_active_o = rd_act & (dir_style | ~ale_i);
    assign mux_mode_o = mux_seen_q;
    assign dir_style_o = dir_style;
    assign addr_o = mux_seen_q ? addr_latch_q : {1'b0, reg_sel_i};
    assign wdata_o = wdata_q;
endmodule

/* channel_regs.v */
// register set of one hdlc channel: mode and slot position
// assumes one-cycle write pulses from the host port front end
`timescale 1ns/1ps
`include "quad_hdlc_consts.vh"
module channel_regs (
    input wire clk_i,
    input wire resetn_i,
    input wire soft_reset_i,
    input wire wr_en_i,
    input wire [3:0] reg_idx_i,
    input wire [7:0] wdata_i,
    input wire irq_pending_i,
    output wire [7:0] mode_o,
    output wire [7:0] slot_pos_o,
    output reg [7:0] rdata_o
);
    reg [7:0] mode_q;
    reg [7:0] slot_pos_q;

    assign mode_o = mode_q;
    assign slot_pos_o = slot_pos_q;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= `MODE_RESET;
            slot_pos_q <= `SLOT_RESET;
        end else if (soft_reset_i) begin
            mode_q <= `MODE_RESET;
            slot_pos_q <= `SLOT_RESET;
        end else if (wr_en_i) begin
            if (reg_idx_i == `CH_REG_MODE) begin
                mode_q <= wdata_i;
            end
            if (reg_idx_i == `CH_REG_SLOT) begin
                slot_pos_q <= wdata_i;
            end
        end
    end

    always @* begin
        case (reg_idx_i)
            `CH_REG_MODE: rdata_o = mode_q;
            `CH_REG_SLOT: rdata_o = slot_pos_q;
            `CH_REG_STATUS: rdata_o = {7'h00, irq_pending_i};
            default: rdata_o = 8'h00;
        endcase
    end
endmodule

/* quad_hdlc_host_port.v */
// host port, common configuration and connection mode logic of the quad hdlc controller
// assumes hdlc cores outside take the slot settings and report pending interrupts
`timescale 1ns/1ps
`include "quad_hdlc_consts.vh"
module quad_hdlc_host_port #(
    parameter NUM_CH = 4
) (
    input wire clk_i,
    input wire resetn_i,
    input wire reset_in_i,
    input wire cs_n_i,
    input wire wr_n_or_dir_i,
    input wire rd_n_or_bus_strobe_i,
    input wire ale_i,
    input wire [7:0] shared_bus_i,
    output reg [7:0] shared_bus_o,
    output wire shared_bus_oe_n_o,
    input wire [6:0] reg_sel_i,
    input wire [1:0] addr_xform_i,
    input wire fsc_strobe_i,
    input wire [NUM_CH-1:0] irq_pending_i,
    output wire int_o,
    output reg int_oe_n_o,
    output reg connection_mode_sel_hi_o,
    output reg connection_mode_sel_lo_o,
    output reg quad_lines_o,
    output reg programmed_slots_o,
    output reg strobe_channels_o,
    output reg iom_fixed_o,
    output reg [NUM_CH-1:0] chan_strobe_active_o,
    output reg [8*NUM_CH-1:0] eff_slot_pos_o,
    output reg [2*NUM_CH-1:0] eff_slot_width_o,
    output reg [2*NUM_CH-1:0] collision_mode_o,
    output reg [NUM_CH-1:0] slave_mode_o,
    output reg [NUM_CH-1:0] multi_master_o,
    output reg [NUM_CH-1:0] uncond_tx_o,
    output reg iom_setup_ok_o,
    output reg mux_mode_o,
    output reg dir_style_o
);
    reg rst_sync1_q;
    reg rst_sync2_q;
    reg [7:0] ccr_q;
    reg [7:0] rdata_mux;
    reg setup_ok;
    wire soft_reset;
    wire [7:0] raw_addr;
    wire [7:0] addr;
    wire [7:0] wdata;
    wire wr_pulse;
    wire rd_active;
    wire bus_mux;
    wire bus_dir;
    wire [1:0] conn;
    wire ch_area;
    wire [1:0] ch_sel;
    wire [3:0] reg_idx;
    wire [8*NUM_CH-1:0] mode_all;
    wire [8*NUM_CH-1:0] slot_all;
    wire [8*NUM_CH-1:0] rdata_all;
    integer k;
    // separate loop index so each process is the only writer of its own
    integer m;

    // halved addresses: bit 0 tells even from odd, so it is dropped
    function [7:0] addr_transform;
        input [7:0] a;
        input [1:0] mode;
        begin
            case (mode)
                `XFORM_EVEN: addr_transform = {1'b0, a[7:1]};
                `XFORM_ODD: addr_transform = {1'b0, a[7:1]};
                default: addr_transform = a;
            endcase
        end
    endfunction

    function [7:0] iom_slot;
        input [1:0] ch;
        begin
            case (ch)
                2'h0: iom_slot = `IOM_SLOT_CH0;
                2'h1: iom_slot = `IOM_SLOT_CH1;
                2'h2: iom_slot = `IOM_SLOT_CH2;
                default: iom_slot = `IOM_SLOT_CH3;
            endcase
        end
    endfunction

    // reset pin is a level: synchronised, then held as a synchronous clear
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= 1'b1;
        end else begin
            rst_sync1_q <= reset_in_i;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign soft_reset = rst_sync2_q;

    host_bus_decoder u_bus (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .soft_reset_i(soft_reset),
        .cs_n_i(cs_n_i),
        .wr_n_or_dir_i(wr_n_or_dir_i),
        .rd_n_or_bus_strobe_i(rd_n_or_bus_strobe_i),
        .ale_i(ale_i),
        .shared_bus_i(shared_bus_i),
        .reg_sel_i(reg_sel_i),
        .mux_mode_o(bus_mux),
        .dir_style_o(bus_dir),
        .addr_o(raw_addr),
        .wdata_o(wdata),
        .wr_pulse_o(wr_pulse),
        .rd_active_o(rd_active)
    );

    assign addr = addr_transform(raw_addr, addr_xform_i);
    assign ch_area = ~addr[`CH_AREA_BIT] & ~addr[6];
    assign ch_sel = addr[`CH_SEL_HI:`CH_SEL_LO];
    assign reg_idx = addr[3:0];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : gen_ch
            channel_regs u_ch (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .soft_reset_i(soft_reset),
                .wr_en_i(wr_pulse & ch_area & (ch_sel == g)),
                .reg_idx_i(reg_idx),
                .wdata_i(wdata),
                .irq_pending_i(irq_pending_i[g]),
                .mode_o(mode_all[8*g +: 8]),
                .slot_pos_o(slot_all[8*g +: 8]),
                .rdata_o(rdata_all[8*g +: 8])
            );
        end
    endgenerate

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ccr_q <= `CCR_RESET;
        end else if (soft_reset) begin
            ccr_q <= `CCR_RESET;
        end else if (wr_pulse && addr == `ADDR_CCR) begin
            ccr_q <= wdata;
        end
    end
    assign conn = ccr_q[`CCR_CONN_LO +: 2];

    // register read decode; unmapped addresses read zero
    always @* begin
        rdata_mux = 8'h00;
        if (ch_area) begin
            rdata_mux = rdata_all[8*ch_sel +: 8];
        end else if (addr == `ADDR_CCR) begin
            rdata_mux = ccr_q;
        end
    end

    // iom mode is only sane once the host has loaded the fixed slot values
    always @* begin
        setup_ok = 1'b1;
        for (m = 0; m < NUM_CH; m = m + 1) begin
            if (mode_all[8*m + `MODE_SLOT_W_LO +: 2] != `IOM_SLOT_W) begin
                setup_ok = 1'b0;
            end
            if (slot_all[8*m +: 8] != iom_slot(m[1:0])) begin
                setup_ok = 1'b0;
            end
        end
    end

    // bus drives only during a selected read, never during a muxed address phase
    assign shared_bus_oe_n_o = ~rd_active;
    // the pin is only ever pulled low; release stands for inactive
    assign int_o = 1'b0;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shared_bus_o <= 8'h00;
            int_oe_n_o <= 1'b1;
            connection_mode_sel_hi_o <= 1'b0;
            connection_mode_sel_lo_o <= 1'b0;
            quad_lines_o <= 1'b0;
            programmed_slots_o <= 1'b0;
            strobe_channels_o <= 1'b0;
            iom_fixed_o <= 1'b0;
            chan_strobe_active_o <= {NUM_CH{1'b0}};
            eff_slot_pos_o <= {8*NUM_CH{1'b0}};
            eff_slot_width_o <= {2*NUM_CH{1'b0}};
            collision_mode_o <= {2*NUM_CH{1'b0}};
            slave_mode_o <= {NUM_CH{1'b0}};
            multi_master_o <= {NUM_CH{1'b0}};
            uncond_tx_o <= {NUM_CH{1'b0}};
            iom_setup_ok_o <= 1'b0;
            mux_mode_o <= 1'b0;
            dir_style_o <= 1'b0;
        end else if (soft_reset) begin
            shared_bus_o <= 8'h00;
            int_oe_n_o <= 1'b1;
            connection_mode_sel_hi_o <= 1'b0;
            connection_mode_sel_lo_o <= 1'b0;
            quad_lines_o <= 1'b0;
            programmed_slots_o <= 1'b0;
            strobe_channels_o <= 1'b0;
            iom_fixed_o <= 1'b0;
            chan_strobe_active_o <= {NUM_CH{1'b0}};
            eff_slot_pos_o <= {8*NUM_CH{1'b0}};
            eff_slot_width_o <= {2*NUM_CH{1'b0}};
            collision_mode_o <= {2*NUM_CH{1'b0}};
            slave_mode_o <= {NUM_CH{1'b0}};
            multi_master_o <= {NUM_CH{1'b0}};
            uncond_tx_o <= {NUM_CH{1'b0}};
            iom_setup_ok_o <= 1'b0;
            mux_mode_o <= 1'b0;
            dir_style_o <= 1'b0;
        end else begin
            shared_bus_o <= rdata_mux;
            int_oe_n_o <= ~(|irq_pending_i);
            connection_mode_sel_hi_o <= conn[1];
            connection_mode_sel_lo_o <= conn[0];
            quad_lines_o <= (conn == `CONN_QUAD_STROBE) | (conn == `CONN_QUAD_SLOT);
            programmed_slots_o <= (conn == `CONN_SINGLE_SLOT) | (conn == `CONN_QUAD_SLOT);
            strobe_channels_o <= (conn == `CONN_QUAD_STROBE);
            iom_fixed_o <= (conn == `CONN_SINGLE_IOM);
            // common strobe marks every channel's time channel at once
            chan_strobe_active_o <= (conn == `CONN_QUAD_STROBE) ?
                                    {NUM_CH{fsc_strobe_i}} : {NUM_CH{1'b0}};
            for (k = 0; k < NUM_CH; k = k + 1) begin
                if (conn == `CONN_SINGLE_IOM) begin
                    eff_slot_pos_o[8*k +: 8] <= iom_slot(k[1:0]);
                    eff_slot_width_o[2*k +: 2] <= `IOM_SLOT_W;
                end else begin
                    eff_slot_pos_o[8*k +: 8] <= slot_all[8*k +: 8];
                    eff_slot_width_o[2*k +: 2] <= mode_all[8*k + `MODE_SLOT_W_LO +: 2];
                end
                collision_mode_o[2*k +: 2] <= mode_all[8*k + `MODE_COLL_LO +: 2];
                slave_mode_o[k] <= mode_all[8*k + `MODE_COLL_LO +: 2] == `COLL_SLAVE;
                multi_master_o[k] <= mode_all[8*k + `MODE_COLL_LO +: 2] == `COLL_MULTI;
                uncond_tx_o[k] <= mode_all[8*k + `MODE_COLL_LO +: 2] == `COLL_UNCOND;
            end
            iom_setup_ok_o <= (conn == `CONN_SINGLE_IOM) & setup_ok;
            mux_mode_o <= bus_mux;
            dir_style_o <= bus_dir;
        end
    end
endmodule

/* host_port_assertions.sv */
// pin-level assertions for the quad hdlc host port and mode outputs
// assumes one clk_i domain, resetn_i async active low, bound by name
`timescale 1ns/1ps
module host_port_assertions #(
    parameter NUM_CH = 4
) (
    input wire clk_i,
    input wire resetn_i,
    input wire reset_in_i,
    input wire cs_n_i,
    input wire wr_n_or_dir_i,
    input wire rd_n_or_bus_strobe_i,
    input wire ale_i,
    input wire fsc_strobe_i,
    input wire [NUM_CH-1:0] irq_pending_i,
    input wire int_o,
    input wire int_oe_n_o,
    input wire shared_bus_oe_n_o,
    input wire connection_mode_sel_hi_o,
    input wire connection_mode_sel_lo_o,
    input wire quad_lines_o,
    input wire programmed_slots_o,
    input wire strobe_channels_o,
    input wire iom_fixed_o,
    input wire [NUM_CH-1:0] chan_strobe_active_o,
    input wire [8*NUM_CH-1:0] eff_slot_pos_o,
    input wire [2*NUM_CH-1:0] eff_slot_width_o,
    input wire [2*NUM_CH-1:0] collision_mode_o,
    input wire [NUM_CH-1:0] slave_mode_o,
    input wire [NUM_CH-1:0] multi_master_o,
    input wire [NUM_CH-1:0] uncond_tx_o,
    input wire iom_setup_ok_o,
    input wire mux_mode_o,
    input wire dir_style_o
);
    // outputs lag the internal reset, so decode checks wait a few edges
    reg [2:0] up_q;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i || reset_in_i) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    wire up = (up_q == 3'h7);
    function [NUM_CH-1:0] dec(input [2*NUM_CH-1:0] cm, input [1:0] code);
        integer k;
        begin
            for (k = 0; k < NUM_CH; k = k + 1) dec[k] = (cm[2*k+:2] == code);
        end
    endfunction
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence read_req;
        !cs_n_i && !rd_n_or_bus_strobe_i && (dir_style_o ? wr_n_or_dir_i : !ale_i);
    endsequence
    sequence dev_reset_held;
        reset_in_i [*4];
    endsequence
    deselect_quiet_a: assert property (cs_n_i |-> shared_bus_oe_n_o)
        else $error("bus driven while deselected");
    read_drive_a: assert property (read_req |-> !shared_bus_oe_n_o)
        else $error("bus not driven during read");
    irq_follow_a: assert property (up |-> int_oe_n_o == !$past(|irq_pending_i))
        else $error("interrupt output does not follow pending");
    int_drain_a: assert property (!int_oe_n_o |-> int_o == 1'b0)
        else $error("interrupt pin not pulled low");
    mode_decode_a: assert property (up |-> quad_lines_o == connection_mode_sel_lo_o
        && programmed_slots_o == (connection_mode_sel_hi_o == connection_mode_sel_lo_o)
        && iom_fixed_o == (connection_mode_sel_hi_o && !connection_mode_sel_lo_o))
        else $error("connection mode decode wrong");
    strobe_follow_a: assert property (up |-> chan_strobe_active_o ==
        (strobe_channels_o ? {NUM_CH{$past(fsc_strobe_i)}} : {NUM_CH{1'b0}}))
        else $error("channel strobe wrong");
    iom_fixed_a: assert property (iom_fixed_o |-> eff_slot_pos_o == 32'h3c2c1c0c
        && eff_slot_width_o == 8'h00) else $error("iom positions wrong");
    coll_decode_a: assert property (up |-> slave_mode_o == dec(collision_mode_o, 2'h1)
        && multi_master_o == dec(collision_mode_o, 2'h2)
        && uncond_tx_o == dec(collision_mode_o, 2'h0)) else $error("collision decode wrong");
    iom_ok_a: assert property (iom_setup_ok_o |-> iom_fixed_o)
        else $error("iom setup flag outside iom mode");
    reset_clear_a: assert property (dev_reset_held |=> !connection_mode_sel_hi_o
        && !connection_mode_sel_lo_o && int_oe_n_o && !mux_mode_o)
        else $error("device reset did not clear");
    mux_sticky_a: assert property (up && mux_mode_o |=> mux_mode_o)
        else $error("muxed mode dropped");
    mux_detect_a: assert property (up && $fell(ale_i) |-> ##[1:2] mux_mode_o)
        else $error("latch enable fall not seen");
    dir_style_a: assert property (dir_style_o |-> !mux_mode_o && $past(ale_i))
        else $error("direction style wrongly flagged");
endmodule
bind quad_hdlc_host_port host_port_assertions #(.NUM_CH(NUM_CH)) chk (.*);

/* host_cpu_model.sv */
// host processor model driving the pin-level host port
// assumes the testbench calls set_style and acc, one access at a time
`timescale 1ns/1ps
module host_cpu_model (
    input wire clk_i,
    input wire [7:0] dout_i,
    input wire oe_n_i,
    output reg cs_n_o,
    output reg wr_o,
    output reg rd_o,
    output reg ale_o,
    output reg [6:0] sel_o,
    output wire [7:0] bus_o
);
    reg drv_q = 1'b0;
    reg [7:0] dq_q = 8'h00;
    integer style = 0;
    // released lines show the inverse of the last value, never a stale copy
    assign bus_o = drv_q ? dq_q : (!oe_n_i ? dout_i : ~dq_q);
    initial begin
        cs_n_o = 1'b1;
        wr_o = 1'b1;
        rd_o = 1'b1;
        ale_o = 1'b0;
        sel_o = 7'h00;
    end
    // 0 separate strobes, 1 direction line, 2 multiplexed
    task set_style(input integer s);
        begin
            @(posedge clk_i);
            style = s;
            ale_o <= (s == 1);
        end
    endtask
    task acc(input w, input [7:0] a, input [7:0] wd, input cs_lvl_n, output [7:0] rv);
        begin
            @(posedge clk_i);
            if (style == 2) begin
                ale_o <= 1'b1;
                drv_q <= 1'b1;
                dq_q <= a;
                @(posedge clk_i);
                ale_o <= 1'b0;
                @(posedge clk_i);
            end
            // separate address pins carry junk in muxed mode
            sel_o <= (style == 2) ? ~a[6:0] : a[6:0];
            drv_q <= w;
            if (w) begin
                dq_q <= wd;
            end
            cs_n_o <= cs_lvl_n;
            wr_o <= !w;
            rd_o <= (style == 1) ? 1'b0 : w;
            repeat (3) @(posedge clk_i);
            rv = bus_o;
            cs_n_o <= 1'b1;
            wr_o <= 1'b1;
            rd_o <= 1'b1;
            drv_q <= 1'b0;
            @(posedge clk_i);
        end
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the quad hdlc host port
// cpu model drives the pins, an integer model of the registers predicts results
`timescale 1ns/1ps
module testbench;
    reg clk_i = 1'b0;
    reg resetn_i = 1'b0;
    reg reset_in_i = 1'b0;
    reg [1:0] addr_xform_i = 2'h0;
    reg fsc_strobe_i = 1'b0;
    reg [3:0] irq_pending_i = 4'h0;
    wire cs_n, wr_n, rd_n, ale, oe_n, hi, lo, quad, prog, strb, iom, ok;
    wire [6:0] sel;
    wire [7:0] bus_i, bus_o, wid, col;
    wire [3:0] slv, mm, unc, cstrb;
    wire int_oe_n, muxm, dirs;
    wire [31:0] pos;
    integer n_errors = 0;
    integer compares = 0;
    integer mdl [0:255];
    reg [31:0] seed = 32'h3642;
    reg [7:0] rv;
    integer i, j, k, m, x;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) fsc_strobe_i <= seed[9];
    host_cpu_model cpu (.clk_i(clk_i), .dout_i(bus_o), .oe_n_i(oe_n), .cs_n_o(cs_n),
        .wr_o(wr_n), .rd_o(rd_n), .ale_o(ale), .sel_o(sel), .bus_o(bus_i));
    quad_hdlc_host_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .reset_in_i(reset_in_i),
        .cs_n_i(cs_n), .wr_n_or_dir_i(wr_n), .rd_n_or_bus_strobe_i(rd_n), .ale_i(ale),
        .shared_bus_i(bus_i), .shared_bus_o(bus_o), .shared_bus_oe_n_o(oe_n),
        .reg_sel_i(sel), .addr_xform_i(addr_xform_i), .fsc_strobe_i(fsc_strobe_i),
        .irq_pending_i(irq_pending_i), .int_o(), .int_oe_n_o(int_oe_n),
        .connection_mode_sel_hi_o(hi), .connection_mode_sel_lo_o(lo), .quad_lines_o(quad),
        .programmed_slots_o(prog), .strobe_channels_o(strb), .iom_fixed_o(iom),
        .chan_strobe_active_o(cstrb), .eff_slot_pos_o(pos), .eff_slot_width_o(wid),
        .collision_mode_o(col), .slave_mode_o(slv), .multi_master_o(mm), .uncond_tx_o(unc),
        .iom_setup_ok_o(ok), .mux_mode_o(muxm), .dir_style_o(dirs));
    function [31:0] xorshift(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xorshift = t ^ (t << 5);
        end
    endfunction
    task step;
        begin
            seed = xorshift(seed);
        end
    endtask
    task test_done;
        begin
            if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk_out(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task chk_rd(input [7:0] got, input [7:0] exp);
        begin
            chk_out({24'h0, got}, {24'h0, exp});
        end
    endtask
    function wbl(input [7:0] ea);
        wbl = ea == 8'h40 || (ea < 8'h40 && ea[3:0] < 4'h2);
    endfunction
    // both transforms drop the low host address bit
    function [7:0] bus_addr(input [7:0] ea);
        bus_addr = (addr_xform_i == 2'h1 || addr_xform_i == 2'h2) ?
            {ea[6:0], addr_xform_i[1]} : ea;
    endfunction
    task wr(input [7:0] ea, input [7:0] d);
        begin
            cpu.acc(1'b1, bus_addr(ea), d, 1'b0, rv);
            if (wbl(ea)) mdl[ea] = d;
        end
    endtask
    task sweep;
        begin
            step;
            @(posedge clk_i) irq_pending_i <= seed[3:0];
            for (j = 0; j < 8'h50; j = j + 1) begin
                cpu.acc(1'b0, bus_addr(j[7:0]), 8'h00, 1'b0, rv);
                chk_rd(rv, wbl(j[7:0]) ? mdl[j][7:0] : (j < 8'h40 && j[3:0] == 4'h2) ?
                    {7'h00, irq_pending_i[j[5:4]]} : 8'h00);
            end
        end
    endtask
    task state;
        reg [31:0] p;
        reg [7:0] w, c;
        reg [11:0] d;
        reg ok_e;
        begin
            repeat (2) @(posedge clk_i);
            m = mdl[8'h40] & 3;
            ok_e = (m == 2);
            for (k = 0; k < 4; k = k + 1) begin
                p[8*k+:8] = (m == 2) ? 8'h0c + 8'h10 * k : mdl[16*k+1];
                w[2*k+:2] = (m == 2) ? 2'h0 : mdl[16*k];
                c[2*k+:2] = mdl[16*k] >> 2;
                d[k] = c[2*k+:2] == 2'h1;
                d[4+k] = c[2*k+:2] == 2'h2;
                d[8+k] = c[2*k+:2] == 2'h0;
                ok_e = ok_e && mdl[16*k][1:0] == 0 && mdl[16*k+1] == 8'h0c + 8'h10 * k;
            end
            chk_out({hi, lo, quad, prog, strb, iom}, {m[1:0], m[0], m == 0 || m == 3, m == 1, m == 2});
            chk_out(pos, p);
            chk_out({wid, col}, {w, c});
            chk_out({slv, mm, unc}, {d[3:0], d[7:4], d[11:8]});
            chk_out(ok, ok_e);
            chk_out(int_oe_n, ~|irq_pending_i);
            chk_out(cstrb, (m == 1) ? {4{seed[9]}} : 4'h0);
            chk_out({muxm, dirs}, {cpu.style == 2, cpu.style == 1});
        end
    endtask
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors = n_errors + 1;
        test_done;
    end
    initial begin
        for (i = 0; i < 256; i = i + 1) mdl[i] = 0;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sweep;
        state;
        for (x = 0; x < 3; x = x + 1) begin
            cpu.set_style(x);
            for (i = 0; i < 4; i = i + 1) begin
                if (x == 2) addr_xform_i <= i[1:0];
                // host addresses are formed from the new transform only after it lands
                @(posedge clk_i);
                wr(8'h40, {6'h00, i[1:0]});
                for (k = 0; k < 12; k = k + 1) begin
                    step;
                    wr({2'h0, seed[5:4], 3'h0, seed[6]}, seed[6] ? seed[15:8] : {4'h0, seed[11:8]});
                end
                cpu.acc(1'b1, 8'h01, seed[23:16], 1'b1, rv);
                wr(8'h53, seed[7:0]);
                sweep;
                state;
            end
            wr(8'h40, 8'h02);
            for (k = 0; k < 4; k = k + 1) begin
                wr(16 * k, (k % 3) << 2);
                wr(16 * k + 1, 8'h0c + 8'h10 * k);
            end
            state;
        end
        @(posedge clk_i) irq_pending_i <= 4'h0;
        reset_in_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        reset_in_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (i = 0; i < 256; i = i + 1) mdl[i] = 0;
        sweep;
        state;
        test_done;
    end
endmodule
